// file: logic/vcpa_core.v
// virtual cpu interface: highest pending readout, aliased binary point, aliased acknowledge
//
// How it works
// - pending readout: id 9:0, core 12:10
// - core number only when hardware flag clear
// - active and pending entries never reported
// - group1 pending gives 1022 unless ack control
// - unlisted pending interrupts may read 1023
// - binary point in bits 2:0, rest reserved
// - aliased ack returns id, acks group1 only
// - group0 entry: return 1023, no acknowledge
// - group1 entry: id, core if software
// - acknowledge makes entry active, sets priority bit
// - nothing signalable: aliased ack returns 1023
// - signalable means interface and hyp gate enabled
`timescale 1ns/1ps
`include "vcpa_regs.vh"
module vcpa_core #(
  parameter ENTRIES = 4,
  parameter IDX_W = 2
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // hypervisor list entry load port
  input wire le_load_i,
  input wire [IDX_W-1:0] le_load_idx_i,
  input wire [1:0] le_load_state_i,
  input wire le_load_group_one_flag_i,
  input wire le_load_hardware_backed_flag_i,
  input wire [7:0] le_load_prio_i,
  input wire [9:0] le_load_ident_i,
  input wire [2:0] le_load_core_i,
  // hypervisor active priorities vector load
  input wire apv_load_i,
  input wire [31:0] apv_load_val_i,
  // observed state
  output wire [2*ENTRIES-1:0] le_state_o,
  output wire [31:0] active_priorities_vector_o,
  output wire ack_pulse_o
);

  // ****************************************
  // state
  // ****************************************
  reg [1:0] le_state_ff [0:ENTRIES-1];
  reg le_group_one_flag_ff [0:ENTRIES-1];
  reg le_hw_ff [0:ENTRIES-1];
  reg [7:0] le_prio_ff [0:ENTRIES-1];
  reg [9:0] le_id_ff [0:ENTRIES-1];
  reg [2:0] le_core_ff [0:ENTRIES-1];
  reg [31:0] apv_ff;
  reg [2:0] bp_ff;
  reg [`VCPA_CTL_MSB:0] ctl_ff;
  reg [31:0] dat_ff;
  reg ack_ff;
  reg ackp_ff;
  reg [2*ENTRIES-1:0] state_flat_ff;

  // ****************************************
  // flattening and selection
  // ****************************************
  wire [2*ENTRIES-1:0] state_flat;
  wire [8*ENTRIES-1:0] prio_flat;
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_flat
      assign state_flat[2*g +: 2] = le_state_ff[g];
      assign prio_flat[8*g +: 8] = le_prio_ff[g];
    end
  endgenerate

  // running priority from lowest set bit of vector, 5-bit groups
  reg [7:0] run_prio;
  integer r;
  always @* begin
    run_prio = 8'hff;
    for (r = 31; r >= 0; r = r - 1) begin
      if (apv_ff[r]) begin
        run_prio = {r[4:0], 3'h0};
      end
    end
  end

  wire sel_found;
  wire [IDX_W-1:0] sel_idx;
  vcpa_select #(
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) u_select (
    .state_i(state_flat),
    .prio_i(prio_flat),
    .run_prio_i(run_prio),
    .found_o(sel_found),
    .index_o(sel_idx)
  );

  // signalable only with interface and hyp gate enabled
  wire sig_ok = sel_found && ctl_ff[`VCPA_CTL_IFEN] && ctl_ff[`VCPA_CTL_HYPEN];
  wire sel_group_one_flag = le_group_one_flag_ff[sel_idx];
  wire [2:0] sel_core = le_hw_ff[sel_idx] ? 3'h0 : le_core_ff[sel_idx];

  // ****************************************
  // read data decode
  // ****************************************
  wire req = wb_cyc_i && wb_stb_i && !ack_ff;
  reg [31:0] nxt_dat;
  reg ack_take;
  always @* begin
    nxt_dat = 32'h0;
    ack_take = 1'b0;
    case (wb_adr_i)
      `VCPA_OFS_HIGHEST_PENDING: begin
        if (!sel_found) begin
          nxt_dat[`VCPA_ID_MSB:0] = `VCPA_ID_SPURIOUS;
        end else if (sel_group_one_flag && !ctl_ff[`VCPA_CTL_ACKCTL]) begin
          nxt_dat[`VCPA_ID_MSB:0] = `VCPA_ID_GROUP1_HIDDEN;
        end else begin
          nxt_dat[`VCPA_ID_MSB:0] = le_id_ff[sel_idx];
          nxt_dat[`VCPA_CORE_MSB:`VCPA_CORE_LSB] = sel_core;
        end
      end
      `VCPA_OFS_BINARY_POINT: begin
        nxt_dat[`VCPA_BP_MSB:0] = bp_ff;
      end
      `VCPA_OFS_ACKNOWLEDGE: begin
        if (!sig_ok || !sel_group_one_flag) begin
          nxt_dat[`VCPA_ID_MSB:0] = `VCPA_ID_SPURIOUS;
        end else begin
          nxt_dat[`VCPA_ID_MSB:0] = le_id_ff[sel_idx];
          nxt_dat[`VCPA_CORE_MSB:`VCPA_CORE_LSB] = sel_core;
          ack_take = !wb_we_i;
        end
      end
      `VCPA_OFS_CONTROL: begin
        nxt_dat[`VCPA_CTL_MSB:0] = ctl_ff;
      end
      default: begin
        nxt_dat = 32'h0;
      end
    endcase
  end

  // ****************************************
  // bus answer and writable registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
      bp_ff <= `VCPA_BP_RESET;
      ctl_ff <= `VCPA_CTL_RESET;
      ackp_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req;
      ackp_ff <= req && ack_take;
      if (req) begin
        dat_ff <= wb_we_i ? 32'h0 : nxt_dat;
      end
      // only binary point and control take writes
      if (req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `VCPA_OFS_BINARY_POINT) begin
          bp_ff <= wb_dat_i[`VCPA_BP_MSB:0];
        end
        if (wb_adr_i == `VCPA_OFS_CONTROL) begin
          ctl_ff <= wb_dat_i[`VCPA_CTL_MSB:0];
        end
      end
    end
  end

  // ****************************************
  // list entries and active priorities vector
  // ****************************************
  integer e;
  always @(posedge clk_i) begin
    if (rst_i) begin
      apv_ff <= 32'h0;
      for (e = 0; e < ENTRIES; e = e + 1) begin
        le_state_ff[e] <= `VCPA_LE_STATE_NONE;
        le_group_one_flag_ff[e] <= 1'b0;
        le_hw_ff[e] <= 1'b0;
        le_prio_ff[e] <= 8'h0;
        le_id_ff[e] <= 10'h0;
        le_core_ff[e] <= 3'h0;
      end
    end else if (ce_i) begin
      // hypervisor load first, acknowledge overrides same entry
      if (le_load_i) begin
        le_state_ff[le_load_idx_i] <= le_load_state_i;
        le_group_one_flag_ff[le_load_idx_i] <= le_load_group_one_flag_i;
        le_hw_ff[le_load_idx_i] <= le_load_hardware_backed_flag_i;
        le_prio_ff[le_load_idx_i] <= le_load_prio_i;
        le_id_ff[le_load_idx_i] <= le_load_ident_i;
        le_core_ff[le_load_idx_i] <= le_load_core_i;
      end
      if (apv_load_i) begin
        apv_ff <= apv_load_val_i;
      end
      if (req && ack_take) begin
        le_state_ff[sel_idx] <= `VCPA_LE_STATE_ACT;
        apv_ff[le_prio_ff[sel_idx][7:3]] <= 1'b1;
      end
    end
  end

  // registered copy of entry states for observation
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_flat_ff <= {2*ENTRIES{1'b0}};
    end else if (ce_i) begin
      state_flat_ff <= state_flat;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign le_state_o = state_flat_ff;
  assign active_priorities_vector_o = apv_ff;
  assign ack_pulse_o = ackp_ff;

endmodule // vcpa_core

// file: logic/vcpa_regs.vh
// register offsets, field positions, reset values and spurious codes for the virtual pending/ack block
`ifndef VCPA_REGS_VH
`define VCPA_REGS_VH
// ****************************************
// register byte offsets
// ****************************************
`define VCPA_OFS_HIGHEST_PENDING 4'h0
`define VCPA_OFS_BINARY_POINT 4'h4
`define VCPA_OFS_ACKNOWLEDGE 4'h8
`define VCPA_OFS_CONTROL 4'hc
// ****************************************
// field positions
// ****************************************
`define VCPA_ID_MSB 9
`define VCPA_CORE_LSB 10
`define VCPA_CORE_MSB 12
`define VCPA_BP_MSB 2
`define VCPA_CTL_ACKCTL 0
`define VCPA_CTL_IFEN 1
`define VCPA_CTL_HYPEN 2
`define VCPA_CTL_MSB 2
// ****************************************
// reset values and special identifiers
// ****************************************
`define VCPA_BP_RESET 3'h0
`define VCPA_CTL_RESET 3'h0
`define VCPA_ID_GROUP1_HIDDEN 10'h3fe
`define VCPA_ID_SPURIOUS 10'h3ff
// ****************************************
// list entry layout
// ****************************************
`define VCPA_LE_STATE_NONE 2'h0
`define VCPA_LE_STATE_PEND 2'h1
`define VCPA_LE_STATE_ACT 2'h2
`define VCPA_LE_STATE_ACTPEND 2'h3
`endif

// file: logic/vcpa_select.v
// picks the highest priority pending list entry that may be signaled
`timescale 1ns/1ps
module vcpa_select #(
  parameter ENTRIES = 4,
  parameter IDX_W = 2
) (
  // list entry state, flattened
  input wire [2*ENTRIES-1:0] state_i,
  input wire [8*ENTRIES-1:0] prio_i,
  // running priority mask
  input wire [7:0] run_prio_i,
  // result
  output reg found_o,
  output reg [IDX_W-1:0] index_o
);

  // ****************************************
  // linear search, lowest value is highest priority
  // ****************************************
  integer k;
  reg [7:0] best;
  always @* begin
    found_o = 1'b0;
    index_o = {IDX_W{1'b0}};
    best = 8'hff;
    for (k = 0; k < ENTRIES; k = k + 1) begin
      // only pure pending entries compete, never active and pending
      if (state_i[2*k +: 2] == `VCPA_LE_STATE_PEND &&
          prio_i[8*k +: 8] < run_prio_i &&
          (!found_o || prio_i[8*k +: 8] < best)) begin
        found_o = 1'b1;
        index_o = k[IDX_W-1:0];
        best = prio_i[8*k +: 8];
      end
    end
  end

endmodule // vcpa_select

// file: test/vcpa_core_asserts.sv
// checker for the virtual pending readout and aliased acknowledge block
`timescale 1ns/1ps
module vcpa_core_asserts #(
  parameter ENTRIES = 4,
  parameter IDX_W = 2
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // bus side
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // observed state
  input wire [2*ENTRIES-1:0] le_state_o,
  input wire [31:0] active_priorities_vector_o,
  input wire ack_pulse_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // request taken, and answer to an aliased acknowledge read
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence alias_rd_s;
    wb_ack_o && $past(wb_adr_i) == 4'h8 && !$past(wb_we_i);
  endsequence
  ack_next_a: assert property (taken_s |=> wb_ack_o) else $error("no ack");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  rsvd_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:13] == 19'h0)
    else $error("reserved bits set");
  bp_field_a: assert property (wb_ack_o && $past(wb_adr_i) == 4'h4 |->
    wb_dat_o[31:3] == 29'h0) else $error("binary point reserved set");
  ro_write_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("write returned data");
  pulse_src_a: assert property (ack_pulse_o |-> alias_rd_s) else $error("stray ack");
  spur_noack_a: assert property (alias_rd_s |-> ack_pulse_o ||
    wb_dat_o[9:0] == 10'h3ff) else $error("failed ack not spurious");
  ack_ident_a: assert property (alias_rd_s ##0 ack_pulse_o |->
    wb_dat_o[9:0] < 10'h3fe) else $error("ack gave special id");
  vec_set_a: assert property (ack_pulse_o |-> ##[0:1]
    active_priorities_vector_o != 32'h0) else $error("vector not set");
  state_move_a: assert property (ack_pulse_o |=> ##1 le_state_o != $past(le_state_o, 2))
    else $error("entry state unchanged");
endmodule // vcpa_core_asserts

bind vcpa_core vcpa_core_asserts #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .le_state_o(le_state_o), .active_priorities_vector_o(active_priorities_vector_o),
  .ack_pulse_o(ack_pulse_o));

// file: test/vcpa_core_tb.sv
// self-checking bench for the virtual pending readout and aliased acknowledge block
`timescale 1ns/1ps
module vcpa_core_tb;
  typedef struct packed {
    logic [2:0] ctl;
    logic [1:0] st;
    logic g;
    logic hw;
    logic [3:0] adr;
    logic pls;
    logic [31:0] exp;
  } vcpa_row_t;
  reg clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0, apv_load_val_i = 32'h0, rd;
  reg le_load_i = 1'b0, apv_load_i = 1'b0, g_i = 1'b0, hw_i = 1'b0, pls;
  reg [1:0] idx_i = 2'h0, st_i = 2'h0;
  reg [7:0] prio_i = 8'h0;
  reg [9:0] id_i = 10'h0;
  wire [31:0] wb_dat_o, apv_o;
  wire [7:0] le_state_o;
  wire wb_ack_o, ack_pulse_o;
  integer error_cnt = 0, n_compared = 0, k;
  vcpa_row_t rows [10] = '{
    '{3'h0, 2'h1, 1'b0, 1'b0, 4'h0, 1'b0, 32'h145a},
    '{3'h0, 2'h1, 1'b1, 1'b0, 4'h0, 1'b0, 32'h3fe},
    '{3'h1, 2'h1, 1'b1, 1'b1, 4'h0, 1'b0, 32'h5a},
    '{3'h1, 2'h3, 1'b1, 1'b0, 4'h0, 1'b0, 32'h3ff},
    '{3'h1, 2'h0, 1'b1, 1'b0, 4'h0, 1'b0, 32'h3ff},
    '{3'h6, 2'h1, 1'b0, 1'b0, 4'h8, 1'b0, 32'h3ff},
    '{3'h6, 2'h1, 1'b1, 1'b0, 4'h8, 1'b1, 32'h145a},
    '{3'h2, 2'h1, 1'b1, 1'b0, 4'h8, 1'b0, 32'h3ff},
    '{3'h4, 2'h1, 1'b1, 1'b0, 4'h8, 1'b0, 32'h3ff},
    '{3'h7, 2'h2, 1'b1, 1'b0, 4'h8, 1'b0, 32'h3ff}};
  vcpa_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .le_load_i(le_load_i),
    .le_load_idx_i(idx_i), .le_load_state_i(st_i), .le_load_group_one_flag_i(g_i),
    .le_load_hardware_backed_flag_i(hw_i), .le_load_prio_i(prio_i), .le_load_ident_i(id_i),
    .le_load_core_i(3'h5), .apv_load_i(apv_load_i), .apv_load_val_i(apv_load_val_i),
    .le_state_o(le_state_o), .active_priorities_vector_o(apv_o), .ack_pulse_o(ack_pulse_o));
  always #5 clk_i = ~clk_i;
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input [3:0] a, input w, input [31:0] d);
    begin
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      pls = ack_pulse_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // load one list entry and clear the priorities vector
  task ld(input [1:0] i, input [1:0] s, input g, input h, input [7:0] p, input [9:0] id);
    begin
      {le_load_i, apv_load_i, idx_i, st_i, g_i, hw_i, prio_i, id_i} <= {2'h3, i, s, g, h, p, id};
      @(posedge clk_i);
      {le_load_i, apv_load_i} <= 2'h0;
      @(posedge clk_i);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt = error_cnt + 1;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(4'h4, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (k = 0; k < 10; k = k + 1) begin
      ld(2'h0, rows[k].st, rows[k].g, rows[k].hw, 8'h40, 10'h05a);
      wb(4'hc, 1'b1, {29'h0, rows[k].ctl});
      wb(rows[k].adr, 1'b0, 32'h0);
      chk(rd, rows[k].exp);
      chk({31'h0, pls}, {31'h0, rows[k].pls});
      if (rows[k].pls)
        chk({apv_o[15:0], 14'h0, le_state_o[1:0]}, 32'h01000002);
      $display("row %0d done", k);
    end
    wb(4'h4, 1'b1, 32'hffffffff);
    wb(4'h4, 1'b0, 32'h0);
    chk(rd, 32'h7);
    wb(4'h6, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ld(2'h0, 2'h1, 1'b1, 1'b0, 8'h40, 10'h05a);
    ld(2'h1, 2'h1, 1'b1, 1'b1, 8'h10, 10'h077);
    wb(4'hc, 1'b1, 32'h7);
    wb(4'h8, 1'b1, 32'h0);
    chk({pls, rd[30:0]}, 32'h0);
    wb(4'h8, 1'b0, 32'h0);
    chk({pls, rd[30:0]}, 32'h80000077);
    wb(4'h8, 1'b0, 32'h0);
    chk({pls, rd[30:0]}, 32'h3ff);
    chk(apv_o, 32'h4);
    $display("back to back acks done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(apv_o, 32'h0);
    wb(4'h4, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    close_out;
  end
endmodule // vcpa_core_tb
